// ### hdl/fcst_pkg.sv
// constants shared by the fast capture serial transmitter
package fcst_pkg;
   // configuration bit positions (bits 7:6 carry nothing)
   localparam int CFG_CLK_SEL = 0;
   localparam int CFG_BYTE_PKG = 1;
   localparam int CFG_GAP = 2;
   localparam int CFG_SET_LO = 3;
   localparam int CFG_POL = 5;
   localparam int CFG_USED_W = 6;
   // word set codes and layouts
   localparam logic [1:0] SET_ALL = 2'h0;
   localparam logic [1:0] SET_WAVE = 2'h1;
   localparam logic [1:0] SET_POWER = 2'h2;
   localparam logic [4:0] ALL_COUNT = 5'h10;
   localparam logic [3:0] WAVE_FIRST = 4'h0;
   localparam logic [4:0] WAVE_COUNT = 5'h07;
   localparam logic [3:0] POWER_FIRST = 4'h7;
   localparam logic [4:0] POWER_COUNT = 5'h09;
   localparam int WORDS = 16;
   localparam int SAMPLE_W = 24;
   localparam int WORD_W = 32;
   localparam logic [4:0] LAST_BIT = 5'h1f;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int FAST_MHZ = 8;
   localparam int SLOW_MHZ = 4;
   localparam int SAMPLE_US = 125;
   localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;
   localparam logic [7:0] ACC_MOD = 8'(CLK_MHZ);
   localparam logic [7:0] STEP_FAST = 8'(2 * FAST_MHZ);
   localparam logic [7:0] STEP_SLOW = 8'(2 * SLOW_MHZ);
   localparam int GAP_CYCLES = 7;
   localparam logic [2:0] GAP_LAST = 3'(GAP_CYCLES - 1);
   // reset values of the pins: all three high
   localparam logic RST_CLOCK = 1'b1;
   localparam logic RST_DATA = 1'b1;
   localparam logic RST_SELECT = 1'b1;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} fcst_state_t;
endpackage

// ### hdl/fcst_top.sv
// fast capture serial transmitter: word fifo and serial engine
`timescale 1ns/1ps

module fcst_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire do_push = in_valid && in_ready;
   wire do_pop = out_valid && out_ready;
   wire ptr_same = wr_ptr[AW-1:0] == rd_ptr[AW-1:0];
   assign in_ready = !(ptr_same && (wr_ptr[AW] != rd_ptr[AW]));
   assign out_valid = !(wr_ptr == rd_ptr);
   assign out_data = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

module fcst_top
   import fcst_pkg::*;
#(
   parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic capture_port_on,
   input wire logic [7:0] capture_port_config,
   input wire logic [WORDS*SAMPLE_W-1:0] sample_words,
   output logic capture_clock,
   output logic capture_data_out,
   output logic capture_select,
   output logic sample_update,
   output logic transfer_busy
);
   // ------------------------------------------------------------
   // sample period timer
   // ------------------------------------------------------------
   logic [15:0] tick_cnt;
   wire sample_tick = tick_cnt == 16'(SAMPLE_PERIOD - 1);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_cnt <= '0;
      else
         tick_cnt <= sample_tick ? 16'h0000 : tick_cnt + 16'h0001;
   end
   assign sample_update = sample_tick;

   // ------------------------------------------------------------
   // transfer start and configuration latch
   // ------------------------------------------------------------
   // a transfer still running at the update swallows that period
   logic xfer_active;
   logic [CFG_USED_W-1:0] cfg_q;
   wire start = sample_tick && capture_port_on && !xfer_active;
   wire [1:0] set_live = capture_port_config[CFG_SET_LO+:2];
   wire [4:0] set_count = (set_live == SET_WAVE) ? WAVE_COUNT :
                          (set_live == SET_POWER) ? POWER_COUNT : ALL_COUNT;
   wire [3:0] set_first = (set_live == SET_POWER) ? POWER_FIRST : WAVE_FIRST;
   wire cfg_slow = cfg_q[CFG_CLK_SEL];
   wire cfg_byte = cfg_q[CFG_BYTE_PKG];
   wire cfg_gap = cfg_q[CFG_GAP];
   wire pol_now = xfer_active ? cfg_q[CFG_POL] : capture_port_config[CFG_POL];
   wire slow_now = xfer_active ? cfg_slow : capture_port_config[CFG_CLK_SEL];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_q <= '0;
      else if (start)
         cfg_q <= capture_port_config[CFG_USED_W-1:0];
   end

   // ------------------------------------------------------------
   // word snapshot and loader
   // ------------------------------------------------------------
   logic [SAMPLE_W-1:0] store [WORDS];
   genvar gi;
   generate
      for (gi = 0; gi < WORDS; gi++)
      begin : g_store
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               store[gi] <= '0;
            else if (start)
               store[gi] <= sample_words[gi*SAMPLE_W+:SAMPLE_W];
         end
      end
   endgenerate

   logic [3:0] load_idx;
   logic [4:0] load_left;
   wire fifo_in_ready;
   wire load_valid = load_left != 5'h00;
   wire load_go = load_valid && fifo_in_ready;
   wire [SAMPLE_W-1:0] load_raw = store[load_idx];
   wire [WORD_W-1:0] load_word = {{(WORD_W-SAMPLE_W){load_raw[SAMPLE_W-1]}}, load_raw};

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         load_idx <= '0;
         load_left <= '0;
      end
      else if (start)
      begin
         load_idx <= set_first;
         load_left <= set_count;
      end
      else if (load_go)
      begin
         load_idx <= load_idx + 4'h1;
         load_left <= load_left - 5'h01;
      end
   end

   wire fifo_out_valid;
   wire [WORD_W-1:0] fifo_out_data;
   logic pop;
   fcst_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(load_valid),
      .in_ready(fifo_in_ready),
      .in_data(load_word),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data)
   );

   // ------------------------------------------------------------
   // capture clock divider
   // ------------------------------------------------------------
   // fractional accumulator: 100/16 is not whole, so half periods
   // run 7, 6, 6, 6 cycles in turn; average rate is exact
   logic [6:0] acc;
   wire [7:0] acc_sum = {1'b0, acc} + (slow_now ? STEP_SLOW : STEP_FAST);
   wire half_en = acc_sum >= ACC_MOD;
   wire [7:0] acc_wrap = acc_sum - ACC_MOD;
   wire [6:0] next_acc = half_en ? acc_wrap[6:0] : acc_sum[6:0];
   wire fall_en = half_en && capture_clock;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc <= '0;
         capture_clock <= RST_CLOCK;
      end
      else
      begin
         acc <= next_acc;
         if (half_en)
            capture_clock <= !capture_clock;
      end
   end

   // ------------------------------------------------------------
   // serial engine
   // ------------------------------------------------------------
   fcst_state_t state;
   fcst_state_t next_state;
   logic [WORD_W-1:0] shreg;
   logic [4:0] cnt;
   logic [2:0] gapcnt;
   logic [4:0] words_left;
   wire word_end = cnt == LAST_BIT;
   wire pkg_end = word_end || (cfg_byte && cnt[2:0] == BYTE_LAST);
   wire last_word = words_left == 5'h00;
   wire gap_done = gapcnt == GAP_LAST;

   always_comb
   begin
      next_state = state;
      pop = 1'b0;
      if (fall_en)
      begin
         unique case (state)
            ST_IDLE:
            begin
               if (xfer_active && fifo_out_valid)
               begin
                  next_state = ST_SHIFT;
                  pop = 1'b1;
               end
            end
            ST_SHIFT:
            begin
               if (word_end && last_word)
                  next_state = ST_IDLE;
               else if (cfg_gap && pkg_end)
                  next_state = ST_GAP;
               else if (word_end)
                  pop = fifo_out_valid;
            end
            ST_GAP:
            begin
               if (gap_done)
               begin
                  next_state = ST_SHIFT;
                  pop = word_end && fifo_out_valid;
               end
            end
         endcase
      end
   end

   wire launch_word = pop;
   wire launch_next = fall_en && !pop &&
                      ((state == ST_SHIFT && next_state == ST_SHIFT && !word_end) ||
                       (state == ST_GAP && gap_done && !word_end));
   wire finish = fall_en && state == ST_SHIFT && next_state == ST_IDLE;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         shreg <= '0;
         cnt <= '0;
         gapcnt <= '0;
         capture_data_out <= RST_DATA;
      end
      else
      begin
         state <= next_state;
         if (launch_word)
         begin
            shreg <= fifo_out_data;
            cnt <= 5'h00;
            capture_data_out <= fifo_out_data[WORD_W-1];
         end
         else if (launch_next)
         begin
            shreg <= shreg << 1;
            cnt <= cnt + 5'h01;
            capture_data_out <= shreg[WORD_W-2];
         end
         else if (finish)
            capture_data_out <= RST_DATA;
         if (fall_en && next_state == ST_GAP)
            gapcnt <= (state == ST_GAP) ? gapcnt + 3'h1 : 3'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         xfer_active <= 1'b0;
         words_left <= '0;
         capture_select <= RST_SELECT;
      end
      else
      begin
         if (start)
         begin
            xfer_active <= 1'b1;
            words_left <= set_count;
         end
         else
         begin
            if (finish)
               xfer_active <= 1'b0;
            if (pop)
               words_left <= words_left - 5'h01;
         end
         capture_select <= pol_now ? (next_state == ST_SHIFT)
                                   : (next_state != ST_SHIFT);
      end
   end
   assign transfer_busy = xfer_active;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_cfg_reserved;
      start |=> cfg_q == $past(capture_port_config[CFG_USED_W-1:0]);
   endproperty
   a_cfg_reserved: assert property (p_cfg_reserved) else $error("config not latched");

   property p_no_gap;
      (xfer_active && !cfg_gap) |-> state != ST_GAP;
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("gap without gap insertion");

   property p_gap_word;
      (fall_en && state == ST_GAP && gap_done && !cfg_byte) |=> state == ST_SHIFT && cnt == 5'h00;
   endproperty
   a_gap_word: assert property (p_gap_word) else $error("word gap length wrong");

   property p_gap_byte;
      (fall_en && state == ST_GAP && gap_done && cfg_byte) |=> cnt[2:0] == 3'h0;
   endproperty
   a_gap_byte: assert property (p_gap_byte) else $error("byte gap length wrong");

   property p_start_every;
      (sample_tick && capture_port_on && !xfer_active) |=> xfer_active && load_valid;
   endproperty
   a_start_every: assert property (p_start_every) else $error("period missed");

   property p_skip_busy;
      (sample_tick && xfer_active && !finish) |=> words_left == $past(words_left) - 5'(pop);
   endproperty
   a_skip_busy: assert property (p_skip_busy) else $error("restart while busy");

   property p_no_starve;
      (fall_en && state == ST_SHIFT && word_end && !last_word && !cfg_gap) |-> fifo_out_valid;
   endproperty
   a_no_starve: assert property (p_no_starve) else $error("fifo ran dry");

   property p_fast_half;
      ($changed(capture_clock) && !slow_now) |=> !$changed(capture_clock) [*5];
   endproperty
   a_fast_half: assert property (p_fast_half) else $error("fast half period short");

   property p_slow_half;
      ($changed(capture_clock) && slow_now && xfer_active) |=> !$changed(capture_clock) [*8];
   endproperty
   a_slow_half: assert property (p_slow_half) else $error("slow half period short");

   property p_data_fall;
      $changed(capture_data_out) |-> $fell(capture_clock);
   endproperty
   a_data_fall: assert property (p_data_fall) else $error("data moved off falling edge");

   property p_set_reserved;
      (start && set_live == 2'h3) |=> load_left == ALL_COUNT && load_idx == WAVE_FIRST;
   endproperty
   a_set_reserved: assert property (p_set_reserved) else $error("set 11 not full");

   property p_select;
      xfer_active |-> ##1 capture_select == ($past(cfg_q[CFG_POL]) ~^ (state == ST_SHIFT));
   endproperty
   a_select: assert property (p_select) else $error("select level wrong");

   property p_snapshot;
      start |=> store[0] == $past(sample_words[SAMPLE_W-1:0]);
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("word not latched");

   c_gapless: cover property (finish && !cfg_gap);
   c_word_gap: cover property (finish && cfg_gap && !cfg_byte);
   c_byte_gap: cover property (finish && cfg_gap && cfg_byte);
   c_skip: cover property (sample_tick && xfer_active);
endmodule

// ### testbench/fcst_rx_model.sv
// serial slave receiver standing on the far side of the capture port
`timescale 1ns/1ps

module fcst_rx_model (
   input wire logic capture_clock,
   input wire logic capture_data_out,
   input wire logic capture_select,
   input wire logic select_polarity,
   input wire logic clear
);
   logic [31:0] words [0:15];
   logic [31:0] shift = 32'h0;
   logic was_active = 1'b0;
   int bits = 0;
   int nwords = 0;
   int packages = 0;
   int gap_run = 0;
   int gap_min = 99;
   int gap_max = 0;
   wire active = (capture_select === select_polarity);

   // -----------------------------------------
   // sampling on rising clock edges only
   // -----------------------------------------
   always @(posedge capture_clock or posedge clear)
   begin
      if (clear)
      begin
         bits = 0;
         nwords = 0;
         packages = 0;
         gap_run = 0;
         gap_min = 99;
         gap_max = 0;
         was_active = 1'b0;
      end
      else if (active)
      begin
         shift = {shift[30:0], capture_data_out};
         bits++;
         if (!was_active)
         begin
            packages++;
            if (gap_run > 0)
            begin
               gap_min = (gap_run < gap_min) ? gap_run : gap_min;
               gap_max = (gap_run > gap_max) ? gap_run : gap_max;
            end
            gap_run = 0;
         end
         if (bits == 32)
         begin
            if (nwords < 16)
               words[nwords] = shift;
            nwords++;
            bits = 0;
         end
         was_active = 1'b1;
      end
      else
      begin
         // idle rises after the first package count as gap
         if (packages > 0)
            gap_run++;
         was_active = 1'b0;
      end
   end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the fast capture serial transmitter
`timescale 1ns/1ps

module testbench;
   import fcst_pkg::*;
   localparam int PERIOD = 7000;
   logic clk;
   logic rst_n = 1'b0;
   logic port_on = 1'b0;
   logic [7:0] cfg = 8'h00;
   logic [WORDS*SAMPLE_W-1:0] samples;
   logic rx_clear = 1'b0;
   wire sclk;
   wire sdata;
   wire ssel;
   wire upd;
   wire busy;
   int num_errors = 0;
   int compares = 0;
   int cyc = 0;

   fcst_top #(.SAMPLE_PERIOD(PERIOD)) dut (.clk(clk), .rst_n(rst_n), .capture_port_on(port_on),
      .capture_port_config(cfg), .sample_words(samples), .capture_clock(sclk),
      .capture_data_out(sdata), .capture_select(ssel), .sample_update(upd),
      .transfer_busy(busy));
   fcst_rx_model rx (.capture_clock(sclk), .capture_data_out(sdata), .capture_select(ssel),
      .select_polarity(cfg[CFG_POL]), .clear(rx_clear));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic logic [23:0] smp(input int i, input logic alt);
      logic [23:0] v;
      v = 24'h80a55a ^ (24'(i) * 24'h0b1357);
      return alt ? ~v : v;
   endfunction

   task automatic load(input logic alt);
      for (int i = 0; i < WORDS; i++)
         samples[24*i +: 24] = smp(i, alt);
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic near(input string what, input int exp, input int got, input int tol);
      compares++;
      if (got < exp - tol || got > exp + tol)
      begin
         num_errors++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic conclude();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wait_busy(input logic lvl, input int bound, output int t);
      int n;
      n = 0;
      while (busy !== lvl && n < bound)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= bound)
      begin
         num_errors++;
         $display("MISMATCH busy expected %0d seen timeout", lvl);
         conclude();
      end
      t = cyc;
   endtask

   // config is set while idle; the mid-run flip changes the samples after the start
   task automatic run_set(input logic [7:0] c, input logic flip, output int t0, output int t1);
      @(negedge clk);
      cfg = c;
      rx_clear = 1'b1;
      @(negedge clk);
      rx_clear = 1'b0;
      wait_busy(1'b1, 2*PERIOD, t0);
      if (flip)
      begin
         repeat (200) @(negedge clk);
         load(1'b1);
      end
      wait_busy(1'b0, 3*PERIOD, t1);
   endtask

   task automatic check_words(input int first, input int n);
      logic [23:0] s;
      check("word count", 32'(n), 32'(rx.nwords));
      for (int k = 0; k < n; k++)
      begin
         s = smp(first + k, 1'b0);
         check("word", {{8{s[23]}}, s}, rx.words[k]);
      end
   endtask

   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   task automatic t_reset_off();
      int n;
      check("reset pins", 32'h7, {29'h0, sclk, sdata, ssel});
      check("reset busy", 32'h0, {31'h0, busy});
      @(negedge clk);
      rst_n = 1'b1;
      n = 0;
      while (upd !== 1'b1 && n < PERIOD + 10)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= PERIOD + 10)
      begin
         num_errors++;
         $display("MISMATCH update expected pulse seen timeout");
         conclude();
      end
      near("first update", PERIOD - 1, n, 0);
      repeat (50) @(negedge clk);
      check("off idle", 32'h1, {30'h0, busy, ssel});
      port_on = 1'b1;
      $display("test reset_off done");
   endtask

   task automatic t_wave_gapless();
      int t0, t1;
      run_set(8'h0a, 1'b0, t0, t1);
      check_words(0, 7);
      check("packages", 32'h1, 32'(rx.packages));
      near("wave time", 2800, t1 - t0, 40);
      $display("test wave_gapless done");
   endtask

   task automatic t_power_gap32();
      int t0, t1;
      run_set(8'hd4, 1'b1, t0, t1);
      check_words(7, 9);
      check("packages", 32'h9, 32'(rx.packages));
      check("gap min", 32'h7, 32'(rx.gap_min));
      check("gap max", 32'h7, 32'(rx.gap_max));
      near("power time", 4300, t1 - t0, 40);
      load(1'b0);
      $display("test power_gap32 done");
   endtask

   task automatic t_wave_byte_slow();
      int t0, t1, t2;
      run_set(8'h2f, 1'b0, t0, t1);
      check_words(0, 7);
      check("packages", 32'd28, 32'(rx.packages));
      check("gap min", 32'h7, 32'(rx.gap_min));
      check("gap max", 32'h7, 32'(rx.gap_max));
      near("slow byte time", 10325, t1 - t0, 60);
      @(negedge clk);
      check("idle high pol", 32'h1, {30'h0, ssel, sdata});
      wait_busy(1'b1, 3*PERIOD, t2);
      near("start spacing", 2*PERIOD, t2 - t0, 1);
      wait_busy(1'b0, 3*PERIOD, t1);
      $display("test wave_byte_slow done");
   endtask

   task automatic t_full_fast();
      int t0, t1, t2, t3;
      run_set(8'h18, 1'b0, t0, t1);
      check_words(0, 16);
      near("full time", 6400, t1 - t0, 40);
      // second period with the plain all-words code
      run_set(8'h00, 1'b0, t2, t3);
      check_words(0, 16);
      near("full time 00", 6400, t3 - t2, 40);
      near("start spacing", PERIOD, t2 - t0, 1);
      $display("test full_fast done");
   endtask

   // -----------------------------------------
   // main sequence
   // -----------------------------------------
   initial
   begin
      load(1'b0);
      repeat (6) @(posedge clk);
      t_reset_off();
      t_wave_gapless();
      t_power_gap32();
      t_wave_byte_slow();
      t_full_fast();
      conclude();
   end
endmodule
